// File: shared/synth_map.svh
// Field positions, widths, reset values, select codes and timing counts
`ifndef SYNTH_MAP_SVH
`define SYNTH_MAP_SVH

`define SHIFT_W             24
`define DEST_MSB            2
`define RF_FB_W             24
`define RF_REF_W            21
`define RF_CTL_W            16
`define SHARED_W            11
`define IF_FB_W             24
`define IF_REF_W            19
`define IF_CTL_W            16
`define LATCH_RST           '0

`define RF_FB_INT_MSB       22
`define RF_FB_INT_LSB       15
`define RF_FB_FRAC_MSB      14
`define RF_FB_FRAC_LSB      3
`define RF_REF_PRESC_BIT    20
`define RF_REF_DBL_BIT      19
`define RF_REF_R_MSB        18
`define RF_REF_R_LSB        15
`define RF_REF_MOD_MSB      14
`define RF_REF_MOD_LSB      3
`define RF_CTL_PD_BIT       5
`define RF_CTL_TRI_BIT      4
`define RF_CTL_CRST_BIT     3
`define SH_SEL_MSB          10
`define SH_SEL_LSB          7
`define SH_PD_BIT           5
`define SH_TRI_BIT          4
`define SH_CRST_BIT         3
`define IF_FB_B_MSB         20
`define IF_FB_B_LSB         9
`define IF_REF_R_MSB        17
`define IF_REF_R_LSB        3

`define STAT_SEL_LOW        4'h0
`define STAT_SEL_DLOCK      4'h1
`define STAT_SEL_RF_REF     4'h2
`define STAT_SEL_RF_FB      4'h3
`define STAT_SEL_ALOCK      4'h4
`define STAT_SEL_IF_REF     4'h5
`define STAT_SEL_IF_FB      4'h6
`define STAT_SEL_RF_DLOCK   4'h7
`define STAT_SEL_IF_DLOCK   4'h8
`define STAT_SEL_HIGH       4'h9

`define REF_CLK_PERIOD_NS   20
`define ABL_WIDTH_NS        40
`define ABL_CYCLES          ((`ABL_WIDTH_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)
`define LD_ERR_NS           60
`define LD_ERR_CYCLES       (`LD_ERR_NS / `REF_CLK_PERIOD_NS)
`define LD_COUNT            4'hf

`endif

// File: shared/synth_pkg.sv
// Types shared by the serial programming and loop logic
package synth_pkg;

  typedef enum logic [2:0] {
    DEST_RF_FB,
    DEST_RF_REF,
    DEST_RF_CTL,
    DEST_SHARED,
    DEST_IF_FB,
    DEST_IF_REF,
    DEST_IF_CTL,
    DEST_NONE
  } dest_t;

  typedef struct packed {
    logic        up;
    logic        dn;
    logic        oe;
  } pump_t;

  typedef struct packed {
    logic [7:0]  int_val;
    logic [11:0] frac;
    logic [11:0] modulus;
    logic [3:0]  r_div;
    logic        prescaler;
    logic        doubler;
  } rf_frac_cfg_t;

endpackage

// File: src/sync2.sv
// Two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic [W-1:0] d_i,
  output var  logic [W-1:0] q_o
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_r <= '0;
      q_o    <= '0;
    end else begin
      meta_r <= d_i;
      q_o    <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: src/pll_lane.sv
// Divider counters, phase detector, pump drive and lock detect of one loop
`timescale 1ns/1ps
`default_nettype none
`include "synth_map.svh"
module pll_lane (
  input  wire logic            clk_i,
  input  wire logic            rst_b_i,
  input  wire logic            run_i,
  input  wire logic            pump_en_i,
  input  wire logic [14:0]     r_div_i,
  input  wire logic [11:0]     n_div_i,
  input  wire logic            fb_i,
  output var  synth_pkg::pump_t pump_o,
  output logic                 phase_act_o,
  output logic                 ref_pulse_o,
  output logic                 fb_pulse_o,
  output logic                 lock_o
);
  import synth_pkg::*;

  logic [14:0] r_cnt_r;
  logic [11:0] n_cnt_r;
  logic        fb_q_r;
  logic        up_r;
  logic        dn_r;
  logic [1:0]  abl_cnt_r;
  logic [2:0]  err_cnt_r;
  logic [3:0]  good_r;
  logic        fb_edge;
  logic        both;
  logic        abl_done;

  assign fb_edge     = fb_i & ~fb_q_r;
  assign both        = up_r & dn_r;
  assign abl_done    = both && (abl_cnt_r == 2'(`ABL_CYCLES - 1));
  assign phase_act_o = up_r | dn_r;

  // Counters sit in load state unless running
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      r_cnt_r     <= '0;
      n_cnt_r     <= '0;
      fb_q_r      <= 1'b0;
      ref_pulse_o <= 1'b0;
      fb_pulse_o  <= 1'b0;
    end else begin
      fb_q_r      <= fb_i;
      ref_pulse_o <= 1'b0;
      fb_pulse_o  <= 1'b0;
      if (!run_i) begin
        r_cnt_r <= '0;
        n_cnt_r <= '0;
      end else begin
        if (r_cnt_r + 15'h1 >= r_div_i) begin
          r_cnt_r     <= '0;
          ref_pulse_o <= 1'b1;
        end else begin
          r_cnt_r <= r_cnt_r + 15'h1;
        end
        if (fb_edge) begin
          if (n_cnt_r + 12'h1 >= n_div_i) begin
            n_cnt_r    <= '0;
            fb_pulse_o <= 1'b1;
          end else begin
            n_cnt_r <= n_cnt_r + 12'h1;
          end
        end
      end
    end
  end

  // Phase detector with fixed antibacklash overlap
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      up_r      <= 1'b0;
      dn_r      <= 1'b0;
      abl_cnt_r <= '0;
    end else begin
      abl_cnt_r <= both ? abl_cnt_r + 2'h1 : 2'h0;
      if (!run_i) begin
        up_r <= 1'b0;
        dn_r <= 1'b0;
      end else begin
        up_r <= ref_pulse_o | (up_r & ~abl_done);
        dn_r <= fb_pulse_o | (dn_r & ~abl_done);
      end
    end
  end

  // Pump drive released while disabled
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pump_o <= '0;
    end else begin
      pump_o.up <= up_r & pump_en_i;
      pump_o.dn <= dn_r & pump_en_i;
      pump_o.oe <= pump_en_i;
    end
  end

  // Digital lock: consecutive cycles with small phase error
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      err_cnt_r <= '0;
      good_r    <= '0;
      lock_o    <= 1'b0;
    end else if (!run_i) begin
      err_cnt_r <= '0;
      good_r    <= '0;
      lock_o    <= 1'b0;
    end else begin
      if (ref_pulse_o) begin
        err_cnt_r <= '0;
        if (err_cnt_r <= 3'(`LD_ERR_CYCLES)) begin
          good_r <= (good_r == `LD_COUNT) ? good_r : good_r + 4'h1;
        end else begin
          good_r <= '0;
        end
      end else if ((up_r ^ dn_r) && (err_cnt_r != 3'h7)) begin
        err_cnt_r <= err_cnt_r + 3'h1;
      end
      lock_o <= (good_r == `LD_COUNT);
    end
  end

  a_antibacklash: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $rose(up_r && dn_r) && run_i |-> (up_r && dn_r)[*2])
    else $error("antibacklash overlap shorter than set width");

endmodule
`default_nettype wire

// File: src/synth_serial_program_latches.sv
// Serial programming latches, power control and status output of the dual synthesizer
// How it works
// - Data bit is captured on each rising serial clock edge.
// - Words shift in MSB first; destination bits land at the bottom.
// - Rising latch strobe copies the shift register into one of seven latches.
// - Destination comes from shifted bits two down to zero at the strobe.
// - Codes 0 to 6 pick RF feedback, reference, control, shared, IF feedback, reference, control.
// - RF feedback latch: reserved bit 23, integer 22:15, fraction 14:3.
// - Status pin shows the source picked by the shared four-bit select field.
// - Status pin offers digital and analog lock; digital lock is high when locked.
// - Analog lock is open drain, high while locked with narrow low pulses.
// - Chip enable high runs normally; low powers both RF and IF loops down.
// - Hardware power-down holds RF and IF divider counters in load state.
// - Hardware power-down releases both charge pump outputs.
// - Hardware power-down resets digital lock detect.
// - Shift register and strobe transfer keep working during power-down.
// - On enable, run only if software power-down bits do not request down.
// - Phase detector compares dividers with a minimum antibacklash overlap.
`timescale 1ns/1ps
`default_nettype none
`include "synth_map.svh"
module synth_serial_program_latches (
  input  wire logic                   REF_CLK_I,
  input  wire logic                   RST_B_I,
  input  wire logic                   SERIAL_CLK_I,
  input  wire logic                   SERIAL_DATA_I,
  input  wire logic                   LATCH_STROBE_I,
  input  wire logic                   CHIP_ENABLE_I,
  input  wire logic                   RF_FB_DIV_I,
  input  wire logic                   IF_FB_DIV_I,
  output logic                        STATUS_OUTPUT_PIN_O,
  output logic                        STATUS_OUTPUT_PIN_OE_O,
  output var  synth_pkg::pump_t       RF_PUMP_O,
  output var  synth_pkg::pump_t       IF_PUMP_O,
  output var  synth_pkg::rf_frac_cfg_t RF_CFG_O,
  output logic [11:0]                 IF_B_DIV_O,
  output logic                        POWERED_UP_O
);
  import synth_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  logic [`SHIFT_W-1:0]  shift_r;
  logic [3:0]           sync_v;
  logic                 le_sync;
  logic                 ce_on;
  logic                 rf_fb_div_s;
  logic                 if_fb_div_s;
  logic                 le_q_r;
  logic                 le_rise;
  dest_t                dest;

  logic [`RF_FB_W-1:0]  rf_fb_r;
  logic [`RF_REF_W-1:0] rf_ref_r;
  logic [`RF_CTL_W-1:0] rf_ctl_r;
  logic [`SHARED_W-1:0] shared_r;
  logic [`IF_FB_W-1:0]  if_fb_r;
  logic [`IF_REF_W-1:0] if_ref_r;
  logic [`IF_CTL_W-1:0] if_ctl_r;

  logic                 rf_pd;
  logic                 if_pd;
  logic                 rf_run;
  logic                 if_run;
  logic                 rf_pump_en;
  logic                 if_pump_en;
  logic [3:0]           out_select;

  logic                 rf_phase_act;
  logic                 if_phase_act;
  logic                 rf_ref_p;
  logic                 rf_fb_p;
  logic                 if_ref_p;
  logic                 if_fb_p;
  logic                 rf_lock;
  logic                 if_lock;

  logic                 stat_out_nxt;
  logic                 stat_oe_nxt;

  // ************************************************************
  // Serial shift register, link clock domain
  // ************************************************************
  always_ff @(posedge SERIAL_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      shift_r <= '0;
    end else begin
      shift_r <= {shift_r[`SHIFT_W-2:0], SERIAL_DATA_I};
    end
  end

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  sync2 #(
    .W (4)
  ) u_pin_sync (
    .clk_i   (REF_CLK_I),
    .rst_b_i (RST_B_I),
    .d_i     ({LATCH_STROBE_I, CHIP_ENABLE_I, RF_FB_DIV_I, IF_FB_DIV_I}),
    .q_o     (sync_v)
  );

  assign le_sync     = sync_v[3];
  assign ce_on       = sync_v[2];
  assign rf_fb_div_s = sync_v[1];
  assign if_fb_div_s = sync_v[0];

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      le_q_r <= 1'b0;
    end else begin
      le_q_r <= le_sync;
    end
  end

  // Word is quiet while the strobe is high, so it is read directly here
  assign le_rise = le_sync & ~le_q_r;
  assign dest    = dest_t'(shift_r[`DEST_MSB:0]);

  // ************************************************************
  // Latch transfer
  // ************************************************************
  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rf_fb_r  <= `LATCH_RST;
      rf_ref_r <= `LATCH_RST;
      rf_ctl_r <= `LATCH_RST;
      shared_r <= `LATCH_RST;
      if_fb_r  <= `LATCH_RST;
      if_ref_r <= `LATCH_RST;
      if_ctl_r <= `LATCH_RST;
    end else if (le_rise) begin
      case (dest)
        DEST_RF_FB: begin
          rf_fb_r <= shift_r[`RF_FB_W-1:0];
        end
        DEST_RF_REF: begin
          rf_ref_r <= shift_r[`RF_REF_W-1:0];
        end
        DEST_RF_CTL: begin
          rf_ctl_r <= shift_r[`RF_CTL_W-1:0];
        end
        DEST_SHARED: begin
          shared_r <= shift_r[`SHARED_W-1:0];
        end
        DEST_IF_FB: begin
          if_fb_r <= shift_r[`IF_FB_W-1:0];
        end
        DEST_IF_REF: begin
          if_ref_r <= shift_r[`IF_REF_W-1:0];
        end
        DEST_IF_CTL: begin
          if_ctl_r <= shift_r[`IF_CTL_W-1:0];
        end
        DEST_NONE: begin
          // Unused code leaves all latches alone
        end
        default: begin
        end
      endcase
    end
  end

  // ************************************************************
  // Field decode
  // ************************************************************
  assign RF_CFG_O.int_val   = rf_fb_r[`RF_FB_INT_MSB:`RF_FB_INT_LSB];
  assign RF_CFG_O.frac      = rf_fb_r[`RF_FB_FRAC_MSB:`RF_FB_FRAC_LSB];
  assign RF_CFG_O.modulus   = rf_ref_r[`RF_REF_MOD_MSB:`RF_REF_MOD_LSB];
  assign RF_CFG_O.r_div     = rf_ref_r[`RF_REF_R_MSB:`RF_REF_R_LSB];
  assign RF_CFG_O.prescaler = rf_ref_r[`RF_REF_PRESC_BIT];
  assign RF_CFG_O.doubler   = rf_ref_r[`RF_REF_DBL_BIT];
  assign IF_B_DIV_O         = if_fb_r[`IF_FB_B_MSB:`IF_FB_B_LSB];
  assign out_select         = shared_r[`SH_SEL_MSB:`SH_SEL_LSB];

  // ************************************************************
  // Power control
  // ************************************************************
  // Chip enable dominates; software bits still gate on return
  assign rf_pd = ~ce_on | shared_r[`SH_PD_BIT] | rf_ctl_r[`RF_CTL_PD_BIT];
  assign if_pd = ~ce_on | shared_r[`SH_PD_BIT];

  assign rf_run = ~rf_pd & ~shared_r[`SH_CRST_BIT] & ~rf_ctl_r[`RF_CTL_CRST_BIT];
  assign if_run = ~if_pd & ~shared_r[`SH_CRST_BIT];

  assign rf_pump_en = ~rf_pd & ~shared_r[`SH_TRI_BIT] & ~rf_ctl_r[`RF_CTL_TRI_BIT];
  assign if_pump_en = ~if_pd & ~shared_r[`SH_TRI_BIT];

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      POWERED_UP_O <= 1'b0;
    end else begin
      POWERED_UP_O <= ~(rf_pd & if_pd);
    end
  end

  // ************************************************************
  // Loops
  // ************************************************************
  pll_lane u_rf_lane (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .run_i       (rf_run),
    .pump_en_i   (rf_pump_en),
    .r_div_i     ({11'h000, RF_CFG_O.r_div}),
    .n_div_i     ({4'h0, RF_CFG_O.int_val}),
    .fb_i        (rf_fb_div_s),
    .pump_o      (RF_PUMP_O),
    .phase_act_o (rf_phase_act),
    .ref_pulse_o (rf_ref_p),
    .fb_pulse_o  (rf_fb_p),
    .lock_o      (rf_lock)
  );

  pll_lane u_if_lane (
    .clk_i       (REF_CLK_I),
    .rst_b_i     (RST_B_I),
    .run_i       (if_run),
    .pump_en_i   (if_pump_en),
    .r_div_i     (if_ref_r[`IF_REF_R_MSB:`IF_REF_R_LSB]),
    .n_div_i     (IF_B_DIV_O),
    .fb_i        (if_fb_div_s),
    .pump_o      (IF_PUMP_O),
    .phase_act_o (if_phase_act),
    .ref_pulse_o (if_ref_p),
    .fb_pulse_o  (if_fb_p),
    .lock_o      (if_lock)
  );

  // ************************************************************
  // Status output multiplexer
  // ************************************************************
  always_comb begin
    stat_out_nxt = 1'b0;
    stat_oe_nxt  = 1'b1;
    case (out_select)
      `STAT_SEL_LOW: begin
        stat_out_nxt = 1'b0;
      end
      `STAT_SEL_DLOCK: begin
        stat_out_nxt = rf_lock & if_lock;
      end
      `STAT_SEL_RF_DLOCK: begin
        stat_out_nxt = rf_lock;
      end
      `STAT_SEL_IF_DLOCK: begin
        stat_out_nxt = if_lock;
      end
      `STAT_SEL_RF_REF: begin
        stat_out_nxt = rf_ref_p;
      end
      `STAT_SEL_RF_FB: begin
        stat_out_nxt = rf_fb_p;
      end
      `STAT_SEL_IF_REF: begin
        stat_out_nxt = if_ref_p;
      end
      `STAT_SEL_IF_FB: begin
        stat_out_nxt = if_fb_p;
      end
      `STAT_SEL_ALOCK: begin
        // Open drain: pull low only while a phase pulse is active
        stat_out_nxt = 1'b0;
        stat_oe_nxt  = rf_phase_act | if_phase_act;
      end
      `STAT_SEL_HIGH: begin
        stat_out_nxt = 1'b1;
      end
      default: begin
        stat_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge REF_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      STATUS_OUTPUT_PIN_O    <= 1'b0;
      STATUS_OUTPUT_PIN_OE_O <= 1'b0;
    end else begin
      STATUS_OUTPUT_PIN_O    <= stat_out_nxt;
      STATUS_OUTPUT_PIN_OE_O <= stat_oe_nxt;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  a_shift_order: assert property (@(posedge SERIAL_CLK_I) disable iff (!RST_B_I)
    ##2 (shift_r[1] == $past(SERIAL_DATA_I, 2)) && (shift_r[0] == $past(SERIAL_DATA_I)))
    else $error("serial bits not shifted in MSB first");

  a_load_one_latch: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h1) |=>
      (rf_ref_r == $past(shift_r[`RF_REF_W-1:0])) && $stable(rf_fb_r) && $stable(if_fb_r))
    else $error("strobe did not load only the RF reference latch");

  a_load_rf_fb: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h0) |=> (rf_fb_r == $past(shift_r)) && $stable(shared_r))
    else $error("RF feedback latch not loaded by code 000");

  a_load_width: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h3) |=> shared_r == $past(shift_r[`SHARED_W-1:0]))
    else $error("shared latch took wrong bits");

  a_unused_code: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h7) |=> $stable(rf_fb_r) && $stable(rf_ref_r) &&
      $stable(rf_ctl_r) && $stable(shared_r) && $stable(if_fb_r) && $stable(if_ref_r) &&
      $stable(if_ctl_r))
    else $error("code 111 changed a latch");

  a_rf_fields: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h1) |=> (RF_CFG_O.r_div == $past(shift_r[18:15])) &&
      (RF_CFG_O.modulus == $past(shift_r[14:3])) && (RF_CFG_O.doubler == $past(shift_r[19])))
    else $error("RF reference fields misplaced");

  a_dlock_mux: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (out_select == `STAT_SEL_DLOCK) |=>
      STATUS_OUTPUT_PIN_OE_O && (STATUS_OUTPUT_PIN_O == $past(rf_lock && if_lock)))
    else $error("digital lock not on status pin");

  a_alock_release: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (out_select == `STAT_SEL_ALOCK) && !rf_phase_act && !if_phase_act |=>
      !STATUS_OUTPUT_PIN_OE_O)
    else $error("analog lock pulled low without phase pulse");

  a_pd_pumps: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ce_on |=> !RF_PUMP_O.oe && !IF_PUMP_O.oe && !RF_PUMP_O.up && !IF_PUMP_O.dn)
    else $error("charge pump driven in power-down");

  a_pd_counters: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ce_on [*2] |-> !rf_ref_p && !if_ref_p && !rf_fb_p && !if_fb_p)
    else $error("divider counters ran in power-down");

  a_pd_lock: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ce_on |=> !rf_lock && !if_lock)
    else $error("lock detect not reset in power-down");

  a_pd_loads: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ce_on && le_rise && (shift_r[2:0] == 3'h4) |=> if_fb_r == $past(shift_r))
    else $error("latch not loaded in power-down");

  a_sw_pd_hold: assert property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    ce_on && shared_r[`SH_PD_BIT] |=> !RF_PUMP_O.oe && !IF_PUMP_O.oe && !POWERED_UP_O)
    else $error("software power-down ignored after enable");

  c_load_in_pd: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    !ce_on && le_rise);

  c_unused_code: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    le_rise && (shift_r[2:0] == 3'h7));

  c_rf_lock: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    $rose(rf_lock));

  c_alock_pulse: cover property (@(posedge REF_CLK_I) disable iff (!RST_B_I)
    (out_select == `STAT_SEL_ALOCK) && STATUS_OUTPUT_PIN_OE_O);

endmodule
`default_nettype wire

// File: test/serial_host.sv
// Host model that shifts words into the three-wire programming port
`timescale 1ns/1ps
`default_nettype none
module serial_host (
  input  wire logic ref_clk_i,
  output var  logic sclk_o,
  output var  logic sdata_o,
  output var  logic strobe_o
);
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    strobe_o = 1'b0;
  end
  // Clock runs only inside a frame; data flips to the inverse once released
  task automatic send(input logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sdata_o = w[i];
      #7.5 sclk_o = 1'b1;
      #7.5 sclk_o = 1'b0;
    end
    sdata_o = ~w[0];
    @(posedge ref_clk_i);
    strobe_o <= 1'b1;
    repeat (6) @(posedge ref_clk_i);
    strobe_o <= 1'b0;
    repeat (4) @(posedge ref_clk_i);
  endtask
endmodule
`default_nettype wire

// File: test/synth_serial_program_latches_test.sv
// Self-checking bench for the serial programming latches
`timescale 1ns/1ps
`default_nettype none
module synth_serial_program_latches_test;
  import synth_pkg::*;
  typedef struct {string name; logic [37:0] v;} note_t;
  logic         ref_clk, rst_b, ce, rf_fb, if_fb, sclk, sdata, strobe, pin, pin_oe, pwr;
  pump_t        rf_pump, if_pump;
  rf_frac_cfg_t cfg, exp_cfg;
  logic [11:0]  if_b;
  logic [23:0]  w;
  note_t        q[$];
  int           failures = 0;
  int           samples_checked = 0;
  event         ev;

  synth_serial_program_latches dut (
    .REF_CLK_I(ref_clk), .RST_B_I(rst_b), .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdata),
    .LATCH_STROBE_I(strobe), .CHIP_ENABLE_I(ce), .RF_FB_DIV_I(rf_fb), .IF_FB_DIV_I(if_fb),
    .STATUS_OUTPUT_PIN_O(pin), .STATUS_OUTPUT_PIN_OE_O(pin_oe), .RF_PUMP_O(rf_pump),
    .IF_PUMP_O(if_pump), .RF_CFG_O(cfg), .IF_B_DIV_O(if_b), .POWERED_UP_O(pwr));
  serial_host host (.ref_clk_i(ref_clk), .sclk_o(sclk), .sdata_o(sdata), .strobe_o(strobe));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    rf_fb <= 1'($urandom);
    if_fb <= 1'($urandom);
  end

  task automatic check(string name, logic [37:0] seen, logic [37:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic note(string s, logic [37:0] v);
    q.push_back('{name: s, v: v});
  endtask
  task automatic settle;
    repeat (5) @(negedge ref_clk);
    ->ev;
    @(negedge ref_clk);
  endtask
  task automatic shared(logic [3:0] sel, logic pd);
    host.send({13'h0, sel, 1'b0, pd, 2'b00, 3'b011});
  endtask
  task automatic test_done;
    if (q.size() != 0) failures++;
    if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Monitor: oldest note against the output it names
  initial begin
    note_t n;
    forever begin
      @(ev);
      while (q.size() > 0) begin
        n = q.pop_front();
        case (n.name)
          "cfg": check(n.name, cfg, n.v);
          "ifb": check(n.name, 38'(if_b), n.v);
          "pin": check(n.name, 38'({pin_oe, pin}), n.v);
          "oe": check(n.name, 38'(pin_oe), n.v);
          "pwr": check(n.name, 38'(pwr), n.v);
          default: check(n.name, 38'({rf_pump.oe, if_pump.oe}), n.v);
        endcase
      end
    end
  end

  initial begin
    repeat (30000) @(posedge ref_clk);
    failures++;
    test_done;
  end

  initial begin
    rst_b = 1'b0;
    ce = 1'b1;
    exp_cfg = '0;
    void'($urandom(32'h41d2461f));
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge ref_clk);
    note("pwr", 38'h1);
    note("pin", 38'h2);
    settle;
    for (int k = 0; k < 3; k++) begin
      w = 24'($urandom);
      host.send({w[23:3], 3'b000});
      exp_cfg.int_val = w[22:15];
      exp_cfg.frac = w[14:3];
      note("cfg", 38'(exp_cfg));
      settle;
      host.send({w[23:3], 3'b001});
      exp_cfg.prescaler = w[20];
      exp_cfg.doubler = w[19];
      exp_cfg.r_div = w[18:15];
      exp_cfg.modulus = w[14:3];
      note("cfg", 38'(exp_cfg));
      host.send({w[23:3], 3'b100});
      note("ifb", 38'(w[20:9]));
      host.send({w[23:6], 3'b000, 3'b010});
      host.send({w[23:3], 3'b110});
      host.send({~w[23:3], 3'b111});
      note("cfg", 38'(exp_cfg));
      note("ifb", 38'(w[20:9]));
      settle;
    end
    shared(4'h9, 1'b0);
    note("pin", 38'h3);
    settle;
    @(posedge ref_clk);
    ce <= 1'b0;
    shared(4'h1, 1'b0);
    note("pwr", 38'h0);
    note("pump", 38'h0);
    note("pin", 38'h2);
    settle;
    shared(4'h4, 1'b0);
    note("oe", 38'h0);
    w = 24'($urandom);
    host.send({w[23:3], 3'b000});
    exp_cfg.int_val = w[22:15];
    exp_cfg.frac = w[14:3];
    note("cfg", 38'(exp_cfg));
    host.send({w[23:3], 3'b100});
    note("ifb", 38'(w[20:9]));
    settle;
    shared(4'h0, 1'b1);
    @(posedge ref_clk);
    ce <= 1'b1;
    note("pwr", 38'h0);
    settle;
    shared(4'h0, 1'b0);
    note("pwr", 38'h1);
    settle;
    test_done;
  end
endmodule
`default_nettype wire
